// [txv_pkg.sv]
// shared constants and types of the text video fetch and dot path
// assumes a single 10 MHz system clock and no register bus
package txv_pkg;

  // ==========================================================================
  // glyph and character layout
  localparam int GLYPH_W = 8;
  localparam int CODE_W = 7;
  localparam int SCAN_W = 4;
  localparam int GLYPH_ADDR_W = CODE_W + SCAN_W;
  localparam int GAP_BIT = 7;

  // ==========================================================================
  // dot and character timing, in dots and character times
  localparam logic [3:0] CHAR_DOTS_80 = 4'ha;
  localparam logic [3:0] CHAR_DOTS_132 = 4'h9;
  localparam logic [2:0] HB_DELAY_80 = 3'h3;
  localparam logic [2:0] HB_DELAY_132 = 3'h5;
  localparam logic [2:0] HOLD_LAG = 3'h3;
  localparam logic [7:0] ADV_LEAD = 8'h03;

  // ==========================================================================
  // screen address counter and pointer bytes
  localparam int CNT_W = 12;
  localparam int MEM_ADDR_W = 15;
  localparam logic [11:0] CNT_RESET = 12'h000;
  localparam logic EXT_RESET = 1'b1;
  localparam int PTR_EXT_BIT = 4;
  localparam int PTR_ATTR_LSB = 5;

  // ==========================================================================
  // one character cell as it arrives at the character latch
  typedef struct packed {
    logic alt_set;
    logic reverse;
    logic [7:0] code;
  } txv_cell_t;

  // glyph rom selection travelling with a cell
  typedef struct packed {
    logic use_alt;
    logic force_fill;
    logic reverse;
  } txv_gsel_t;

endpackage

// [txv_video_path.sv]
// character fetch, glyph addressing, dot shifter and terminator logic
// assumes screen memory data and glyph rom data are synchronous to clk_sys;
// hold acknowledge, line buffer address bit 4 and other pins are asynchronous
`timescale 1ns/1ps
`default_nettype none

// Operation
// - glyph address is seven code bits above four scan count bits
// - glyph rom words are eight dot bits of one scan row
// - alternate set on fitted rom selects alternate rom, disables main
// - alternate set without alternate rom shows full lit, dark if reversed
// - load puts seven bits in shifter, eighth in gap flop, last dot first
// - shifter keeps its top bit at load so the previous last dot repeats
// - gap flop feeds serial input, filling one or two extra dots
// - horizontal blank forces gap flop output low
// - terminator compare uses only the seven code bits
// - each row ends with terminator then two pointer bytes
// - terminator blanks video and ends the hold request
// - pointer bit loads extension flop, top three bits give line attributes
// - pointer load before next character clock loads counters and attributes
// - pointer load comes from falling edge of hold request
// - terminate output low for exactly one character clock
// - terminator blank is black normally, background in reverse screen
// - terminate flop held cleared during horizontal blank
// - horizontal blank starts 3 or 5 characters after terminator, forces black
// - raw blank ends half a character early, resynchronised to character clock
// - hold request starts on scan zero or scroll zone, ends on terminator
// - hold request start lags blank start by three characters
// - fetch grant samples hold acknowledge on first bit 4 rise
// - address count starts one character before blank ends
// - vertical reset presets screen address to 2000H
module txv_video_path #(
  parameter int DOT_DIV = 1,
  parameter logic [7:0] HBLANK_CHARS = 8'h14,
  parameter logic [6:0] TERM_CODE = 7'h7f
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic col132,
  input wire logic reverse_screen,
  input wire logic vertical_reset,
  input wire logic scan_zero,
  input wire logic new_scroll_zone,
  input wire logic [3:0] scan_count,
  input wire logic hold_acknowledge,
  input wire logic line_buffer_addr_bit4,
  input wire logic alt_rom_fitted,
  input wire txv_pkg::txv_cell_t cell_in,
  input wire logic [7:0] main_glyph_data,
  input wire logic [7:0] alt_glyph_data,
  output logic [10:0] glyph_addr,
  output logic main_rom_en,
  output logic alt_glyph_select_n,
  output logic shifter_load,
  output logic video_dot,
  output logic terminate_n,
  output logic hold_request,
  output logic fetch_grant,
  output logic mem_read_n,
  output logic mem_addr_oe,
  output logic [14:0] mem_addr,
  output logic fetch_address_advance,
  output logic pointer_load_n,
  output logic [2:0] line_attr,
  output logic hblank
);

  // ==========================================================================
  // pin synchronisers
  logic ack_s1_q, ack_s2_q, lba_s1_q, lba_s2_q, lba_s3_q;
  logic vrst_s1_q, vrst_s2_q, zero_s1_q, zero_s2_q;
  logic scr_s1_q, scr_s2_q, scr_s3_q, fit_s1_q, fit_s2_q;

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      {ack_s1_q, ack_s2_q, lba_s1_q, lba_s2_q, lba_s3_q} <= 5'h00;
      {vrst_s1_q, vrst_s2_q, zero_s1_q, zero_s2_q} <= 4'h0;
      {scr_s1_q, scr_s2_q, scr_s3_q, fit_s1_q, fit_s2_q} <= 5'h00;
    end else begin
      ack_s1_q <= hold_acknowledge;
      ack_s2_q <= ack_s1_q;
      lba_s1_q <= line_buffer_addr_bit4;
      lba_s2_q <= lba_s1_q;
      lba_s3_q <= lba_s2_q;
      vrst_s1_q <= vertical_reset;
      vrst_s2_q <= vrst_s1_q;
      zero_s1_q <= scan_zero;
      zero_s2_q <= zero_s1_q;
      scr_s1_q <= new_scroll_zone;
      scr_s2_q <= scr_s1_q;
      scr_s3_q <= scr_s2_q;
      fit_s1_q <= alt_rom_fitted;
      fit_s2_q <= fit_s1_q;
    end
  end

  // ==========================================================================
  // dot and character enables
  logic [7:0] div_q;
  logic [3:0] dot_cnt_q;
  logic dot_en, char_en, half_char;
  logic [3:0] char_dots;

  assign char_dots = col132 ? txv_pkg::CHAR_DOTS_132 : txv_pkg::CHAR_DOTS_80;
  assign dot_en = (div_q == 8'(DOT_DIV - 1));
  assign char_en = dot_en && (dot_cnt_q == char_dots - 4'h1);
  assign half_char = dot_en && (dot_cnt_q == (char_dots >> 1));

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      div_q <= 8'h00;
      dot_cnt_q <= 4'h0;
    end else begin
      div_q <= dot_en ? 8'h00 : div_q + 8'h01;
      if (char_en) begin
        dot_cnt_q <= 4'h0;
      end else if (dot_en) begin
        dot_cnt_q <= dot_cnt_q + 4'h1;
      end
    end
  end

  // ==========================================================================
  // character latches and glyph rom addressing
  txv_pkg::txv_cell_t c1_q, c2_q;
  txv_pkg::txv_gsel_t gsel_q;
  logic [7:0] glyph;

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      c1_q <= '0;
      c2_q <= '0;
      gsel_q <= '0;
      glyph_addr <= 11'h000;
      main_rom_en <= 1'b1;
      alt_glyph_select_n <= 1'b1;
    end else if (char_en) begin
      c1_q <= cell_in;
      c2_q <= c1_q;
      glyph_addr <= {c1_q.code[6:0], scan_count};
      gsel_q.use_alt <= c1_q.alt_set && fit_s2_q;
      gsel_q.force_fill <= c1_q.alt_set && !fit_s2_q;
      gsel_q.reverse <= c1_q.reverse;
      alt_glyph_select_n <= !(c1_q.alt_set && fit_s2_q);
      main_rom_en <= !(c1_q.alt_set && fit_s2_q);
    end
  end

  always_comb begin
    if (gsel_q.force_fill) begin
      glyph = gsel_q.reverse ? 8'h00 : 8'hff;
    end else if (gsel_q.use_alt) begin
      glyph = alt_glyph_data;
    end else begin
      glyph = main_glyph_data;
    end
  end

  // ==========================================================================
  // dot shifter with gap flop
  logic [7:0] shreg_q;
  logic gap_q, dot_q, hb_raw_q;

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      shreg_q <= 8'h00;
      gap_q <= 1'b0;
      dot_q <= 1'b0;
      shifter_load <= 1'b0;
    end else begin
      shifter_load <= char_en;
      if (char_en) begin
        shreg_q <= {shreg_q[7], glyph[6:0]};
        gap_q <= glyph[txv_pkg::GAP_BIT];
        dot_q <= shreg_q[7];
      end else if (dot_en) begin
        shreg_q <= {shreg_q[6:0], gap_q && !hb_raw_q};
        dot_q <= shreg_q[7];
      end
    end
  end

  // ==========================================================================
  // terminator detect and horizontal blank
  logic term_match, term_hit, term_ff_q, hb_sync_q;
  logic [2:0] hb_pend_q, lag_q;
  logic [7:0] hb_left_q;
  logic [7:0] ptr_lo_q, ptr_hi_q;

  assign term_match = (c2_q.code[6:0] == TERM_CODE);
  assign term_hit = char_en && term_match && !hb_raw_q;

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      term_ff_q <= 1'b0;
      terminate_n <= 1'b1;
      ptr_lo_q <= 8'h00;
      ptr_hi_q <= 8'h00;
    end else begin
      if (hb_raw_q) begin
        term_ff_q <= 1'b0;
      end else if (term_hit) begin
        term_ff_q <= 1'b1;
      end
      if (term_hit) begin
        terminate_n <= 1'b0;
        ptr_lo_q <= c1_q.code;
        ptr_hi_q <= cell_in.code;
      end else if (char_en) begin
        terminate_n <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      hb_pend_q <= 3'h0;
      hb_left_q <= 8'h00;
      hb_raw_q <= 1'b0;
      hb_sync_q <= 1'b0;
    end else begin
      if (term_hit) begin
        hb_pend_q <= col132 ? txv_pkg::HB_DELAY_132 : txv_pkg::HB_DELAY_80;
      end else if (char_en && hb_pend_q != 3'h0) begin
        hb_pend_q <= hb_pend_q - 3'h1;
      end
      if (char_en && hb_pend_q == 3'h1) begin
        hb_raw_q <= 1'b1;
        hb_left_q <= HBLANK_CHARS;
      end else if (hb_raw_q && hb_left_q == 8'h01 && half_char) begin
        hb_raw_q <= 1'b0;
      end else if (hb_raw_q && char_en && hb_left_q != 8'h01) begin
        hb_left_q <= hb_left_q - 8'h01;
      end
      // the rise is already on a character edge, so only the mid-character fall needs resync
      if (char_en && hb_pend_q == 3'h1) begin
        hb_sync_q <= 1'b1;
      end else if (char_en) begin
        hb_sync_q <= hb_raw_q;
      end
    end
  end

  // ==========================================================================
  // hold request, fetch grant and address advance
  logic scroll_q, lba_seen_q, adv_win_q, hold_d1_q, adv, hold_start;

  assign hold_start = char_en && lag_q == 3'h1 && (zero_s2_q || scroll_q) && !term_ff_q;
  assign adv = char_en && hold_request && adv_win_q;

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      lag_q <= 3'h0;
      scroll_q <= 1'b0;
      hold_request <= 1'b0;
      adv_win_q <= 1'b0;
    end else begin
      if (char_en && hb_pend_q == 3'h1) begin
        lag_q <= txv_pkg::HOLD_LAG;
      end else if (char_en && lag_q != 3'h0) begin
        lag_q <= lag_q - 3'h1;
      end
      if (scr_s2_q && !scr_s3_q) begin
        scroll_q <= 1'b1;
      end else if (hold_start) begin
        scroll_q <= 1'b0;
      end
      if (term_hit) begin
        hold_request <= 1'b0;
      end else if (hold_start) begin
        hold_request <= 1'b1;
      end
      if (term_hit) begin
        adv_win_q <= 1'b0;
      end else if (char_en && hb_raw_q && hb_left_q == txv_pkg::ADV_LEAD) begin
        adv_win_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      lba_seen_q <= 1'b0;
      fetch_grant <= 1'b0;
      mem_read_n <= 1'b1;
      mem_addr_oe <= 1'b0;
      fetch_address_advance <= 1'b0;
    end else begin
      fetch_address_advance <= adv;
      if (!hold_request) begin
        lba_seen_q <= 1'b0;
        fetch_grant <= 1'b0;
        mem_read_n <= 1'b1;
        mem_addr_oe <= 1'b0;
      end else if (lba_s2_q && !lba_s3_q && !lba_seen_q) begin
        lba_seen_q <= 1'b1;
        fetch_grant <= ack_s2_q;
        mem_read_n <= !ack_s2_q;
        mem_addr_oe <= ack_s2_q;
      end
    end
  end

  // ==========================================================================
  // screen address counter and pointer load
  logic [11:0] cnt_q;
  logic ext_q;

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      hold_d1_q <= 1'b0;
      pointer_load_n <= 1'b1;
      cnt_q <= txv_pkg::CNT_RESET;
      ext_q <= txv_pkg::EXT_RESET;
      line_attr <= 3'h0;
      mem_addr <= {!txv_pkg::EXT_RESET, txv_pkg::EXT_RESET, 1'b0, txv_pkg::CNT_RESET};
    end else begin
      hold_d1_q <= hold_request;
      pointer_load_n <= !(hold_d1_q && !hold_request);
      if (vrst_s2_q) begin
        cnt_q <= txv_pkg::CNT_RESET;
        ext_q <= txv_pkg::EXT_RESET;
      end else if (hold_d1_q && !hold_request) begin
        cnt_q <= {ptr_hi_q[3:0], ptr_lo_q};
        ext_q <= ptr_hi_q[txv_pkg::PTR_EXT_BIT];
        line_attr <= ptr_hi_q[7:txv_pkg::PTR_ATTR_LSB];
      end else if (adv) begin
        cnt_q <= cnt_q + 12'h001;
      end
      mem_addr <= {!ext_q, ext_q, 1'b0, cnt_q};
    end
  end

  // ==========================================================================
  // video output
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      video_dot <= 1'b0;
      hblank <= 1'b0;
    end else begin
      hblank <= hb_sync_q;
      if (dot_en) begin
        if (hb_sync_q) begin
          video_dot <= 1'b0;
        end else if (term_ff_q) begin
          video_dot <= reverse_screen;
        end else begin
          video_dot <= dot_q ^ reverse_screen;
        end
      end
    end
  end

  // ==========================================================================
  // assertions
  property p_glyph_addr;
    @(posedge clk_sys) disable iff (!rstn)
    char_en |=> glyph_addr == {$past(c1_q.code[6:0]), $past(scan_count)};
  endproperty
  a_glyph_addr: assert property (p_glyph_addr) else $error("glyph address mismatch");

  property p_force_fill;
    @(posedge clk_sys) disable iff (!rstn)
    char_en && gsel_q.force_fill |=> shreg_q[6:0] == ($past(gsel_q.reverse) ? 7'h00 : 7'h7f);
  endproperty
  a_force_fill: assert property (p_force_fill) else $error("missing alt rom fill wrong");

  property p_first_dot;
    @(posedge clk_sys) disable iff (!rstn)
    char_en |=> shreg_q[7] == dot_q;
  endproperty
  a_first_dot: assert property (p_first_dot) else $error("previous last dot not repeated");

  property p_gap_in;
    @(posedge clk_sys) disable iff (!rstn)
    dot_en && !char_en |=> shreg_q[0] == $past(gap_q && !hb_raw_q);
  endproperty
  a_gap_in: assert property (p_gap_in) else $error("gap bit not shifted in");

  property p_term_ends_hold;
    @(posedge clk_sys) disable iff (!rstn)
    term_hit |=> !hold_request && !terminate_n ##1 pointer_load_n == !$past(hold_request, 2);
  endproperty
  a_term_ends_hold: assert property (p_term_ends_hold) else $error("terminator did not end hold");

  property p_term_one_char;
    @(posedge clk_sys) disable iff (!rstn)
    !terminate_n && char_en |=> terminate_n;
  endproperty
  a_term_one_char: assert property (p_term_one_char) else $error("terminate held too long");

  property p_ptr_load;
    @(posedge clk_sys) disable iff (!rstn)
    $fell(hold_request) |=> !pointer_load_n ##1 pointer_load_n;
  endproperty
  a_ptr_load: assert property (p_ptr_load) else $error("pointer load pulse wrong");

  property p_grant_clear;
    @(posedge clk_sys) disable iff (!rstn)
    !hold_request |=> !fetch_grant && mem_read_n;
  endproperty
  a_grant_clear: assert property (p_grant_clear) else $error("grant outlived hold");

  property p_vreset;
    @(posedge clk_sys) disable iff (!rstn)
    vrst_s2_q |=> cnt_q == 12'h000 && ext_q ##1 mem_addr == 15'h2000;
  endproperty
  a_vreset: assert property (p_vreset) else $error("vertical reset preset wrong");

  property p_hold_start;
    @(posedge clk_sys) disable iff (!rstn)
    $rose(hold_request) |-> $past(!term_ff_q) && $past(lag_q) == 3'h1;
  endproperty
  a_hold_start: assert property (p_hold_start) else $error("hold started at wrong time");

  c_hold: cover property (@(posedge clk_sys) disable iff (!rstn) $rose(hold_request));
  c_grant: cover property (@(posedge clk_sys) disable iff (!rstn) $rose(fetch_grant));
  c_ptr: cover property (@(posedge clk_sys) disable iff (!rstn) !pointer_load_n);
  c_term: cover property (@(posedge clk_sys) disable iff (!rstn) term_hit);

endmodule

`default_nettype wire

// [txv_host_model.sv]
// host processor side of the shared screen memory bus
// assumes hold requests come from the video path on clk_sys
`timescale 1ns/1ps
`default_nettype none

module txv_host_model (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic hold_request,
  input wire logic [7:0] ack_delay,
  output logic hold_acknowledge
);
  // ==========================================================================
  // bus release
  logic [7:0] wait_q;

  // acknowledge after ack_delay clocks, kept until the request is withdrawn
  always_ff @(posedge clk_sys) begin
    if (!rstn || !hold_request) begin
      wait_q <= 8'h00;
      hold_acknowledge <= 1'b0;
    end else if (wait_q >= ack_delay) begin
      hold_acknowledge <= 1'b1;
    end else begin
      wait_q <= wait_q + 8'h01;
    end
  end
endmodule

`default_nettype wire

// [txv_video_path_test.sv]
// self-checking bench of the text video path, cells driven at the latch
// assumes txv_pkg and txv_host_model are compiled first
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("ERROR %0t: mismatch at line %0d", $time, `__LINE__); end end

module txv_video_path_test;
  // ==========================================================================
  // signals
  logic clk_sys, rstn, col132, reverse_screen, vertical_reset, scan_zero, new_scroll_zone;
  logic hold_acknowledge, line_buffer_addr_bit4, alt_rom_fitted;
  logic [3:0] scan_count;
  logic [7:0] main_glyph_data, alt_glyph_data, host_delay;
  txv_pkg::txv_cell_t cell_in;
  logic [10:0] glyph_addr;
  logic main_rom_en, alt_glyph_select_n, shifter_load, video_dot, terminate_n, hold_request;
  logic fetch_grant, mem_read_n, mem_addr_oe, fetch_address_advance, pointer_load_n, hblank;
  logic [14:0] mem_addr;
  logic [2:0] line_attr;
  int bad_count = 0;
  int n_checks = 0;
  int cyc = 0;

  txv_video_path #(.DOT_DIV(1), .HBLANK_CHARS(8'h06), .TERM_CODE(7'h7f)) txv_video_path_i (
    .clk_sys, .rstn, .col132, .reverse_screen, .vertical_reset, .scan_zero, .new_scroll_zone,
    .scan_count, .hold_acknowledge, .line_buffer_addr_bit4, .alt_rom_fitted, .cell_in,
    .main_glyph_data, .alt_glyph_data, .glyph_addr, .main_rom_en, .alt_glyph_select_n,
    .shifter_load, .video_dot, .terminate_n, .hold_request, .fetch_grant, .mem_read_n,
    .mem_addr_oe, .mem_addr, .fetch_address_advance, .pointer_load_n, .line_attr, .hblank
  );

  txv_host_model txv_host_model_i (
    .clk_sys, .rstn, .hold_request, .ack_delay(host_delay), .hold_acknowledge
  );

  // ==========================================================================
  // clock, watchdog and verdict
  always #50 clk_sys = ~clk_sys;

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      bad_count++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // ==========================================================================
  // access tasks
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  function automatic logic sig(input int w);
    case (w)
      0: return terminate_n;
      1: return hblank;
      2: return hold_request;
      default: return shifter_load;
    endcase
  endfunction

  task automatic wait_for(input int w, input logic v, output int n);
    n = 0;
    while (sig(w) !== v && n < 400) begin
      tick(1);
      n++;
    end
    if (n >= 400) begin
      bad_count++;
      $display("ERROR %0t: wait timed out", $time);
    end
  endtask

  // one cell per character time, changed just after the shifter load
  task automatic send(input logic [7:0] c);
    int n;
    wait_for(3, 1'b1, n);
    cell_in = '{alt_set: 1'b0, reverse: 1'b0, code: c};
    tick(1);
  endtask

  task automatic dots(input logic m, input logic [7:0] g, input logic rs);
    logic pat [10];
    logic seen [20];
    logic ok, hit;
    int per, nl;
    per = m ? 9 : 10;
    col132 = m;
    main_glyph_data = g;
    reverse_screen = rs;
    tick(60);
    pat[0] = g[7];
    for (int i = 0; i < 7; i++) pat[i + 1] = g[6 - i];
    for (int i = 8; i < per; i++) pat[i] = g[7];
    nl = 0;
    for (int i = 0; i < 2 * per; i++) begin
      seen[i] = video_dot;
      nl += shifter_load;
      tick(1);
    end
    hit = 1'b0;
    for (int r = 0; r < per; r++) begin
      ok = 1'b1;
      for (int i = 0; i < 2 * per; i++) if (seen[i] !== (pat[(i + r) % per] ^ rs)) ok = 1'b0;
      hit |= ok;
    end
    `CHK(hit, 1'b1)
    `CHK(nl, 2)
  endtask

  // one text row: cells, terminator, two pointer bytes, then the retrace
  task automatic line(input logic m, input logic [7:0] hi, input logic sz, input logic scr,
                      input logic hold, input logic slow);
    int per, d, n, n2, t_hb, k;
    logic h, pl;
    logic [14:0] a0;
    per = m ? 9 : 10;
    d = m ? 5 : 3;
    col132 = m;
    reverse_screen = m;
    scan_zero = sz;
    host_delay = slow ? 8'h0f : 8'h01;
    h = hold_request;
    for (int i = 0; i < 3; i++) send(8'h41);
    send(8'hff);
    send(8'h34);
    send(hi);
    wait_for(0, 1'b0, n);
    cell_in.code = 8'h41;
    `CHK(hold_request, 1'b0)
    pl = 1'b0;
    for (int i = 0; i < 4; i++) begin
      pl |= ~pointer_load_n;
      tick(1);
    end
    `CHK(pl, h)
    if (h) begin
      `CHK(line_attr, hi[7:5])
      `CHK(mem_addr, {~hi[4], hi[4], 1'b0, hi[3:0], 8'h34})
      `CHK(fetch_grant, 1'b0)
    end
    `CHK(video_dot, m)
    wait_for(0, 1'b1, n);
    `CHK(n + 4, per)
    wait_for(1, 1'b1, n2);
    t_hb = cyc;
    `CHK((n + n2 + 4 - d * per) inside {[0:2]}, 1'b1)
    tick(2);
    `CHK(video_dot, 1'b0)
    if (scr) begin
      new_scroll_zone = 1'b1;
      tick(3);
      new_scroll_zone = 1'b0;
    end
    if (hold) begin
      wait_for(2, 1'b1, n);
      `CHK((cyc - t_hb) inside {[3 * per - 3:3 * per + 1]}, 1'b1)
      tick(6);
      line_buffer_addr_bit4 = 1'b1;
      tick(5);
      line_buffer_addr_bit4 = 1'b0;
      `CHK({fetch_grant, mem_read_n, mem_addr_oe}, slow ? 3'b010 : 3'b101)
      if (slow) begin
        tick(12);
        line_buffer_addr_bit4 = 1'b1;
        tick(5);
        line_buffer_addr_bit4 = 1'b0;
        `CHK(fetch_grant, 1'b0)
      end
      a0 = mem_addr;
      k = 0;
      // a pulse shows one clock before the address it moved, so count before each step
      for (int i = 0; i < 3 * per; i++) begin
        k += fetch_address_advance;
        tick(1);
      end
      `CHK(mem_addr - a0, 15'(k))
      `CHK(k >= 2, 1'b1)
    end else begin
      send(8'hff);
      send(8'h41);
      tick(per);
      `CHK(terminate_n, 1'b1)
      tick(3 * per);
      `CHK(hold_request, 1'b0)
    end
  endtask

  // ==========================================================================
  // test sequence
  initial begin
    {clk_sys, rstn, col132, reverse_screen, vertical_reset, scan_zero, new_scroll_zone} = 7'h00;
    {line_buffer_addr_bit4, alt_rom_fitted} = 2'h0;
    scan_count = 4'h0;
    main_glyph_data = 8'h00;
    alt_glyph_data = 8'h00;
    host_delay = 8'h01;
    cell_in = '{alt_set: 1'b0, reverse: 1'b0, code: 8'h41};
    tick(6);
    `CHK(mem_addr, 15'h2000)
    `CHK({terminate_n, pointer_load_n, mem_read_n, hold_request, fetch_grant, mem_addr_oe}, 6'h38)
    rstn = 1'b1;
    tick(4);
    cell_in.code = 8'hc5;
    scan_count = 4'h9;
    tick(40);
    `CHK(glyph_addr, {7'h45, 4'h9})
    cell_in.alt_set = 1'b1;
    alt_rom_fitted = 1'b1;
    tick(40);
    `CHK({alt_glyph_select_n, main_rom_en}, 2'b00)
    alt_rom_fitted = 1'b0;
    tick(40);
    `CHK({alt_glyph_select_n, main_rom_en}, 2'b11)
    for (int i = 0; i < 20; i++) begin
      tick(1);
      `CHK(video_dot, 1'b1)
    end
    cell_in.reverse = 1'b1;
    tick(40);
    for (int i = 0; i < 20; i++) begin
      tick(1);
      `CHK(video_dot, 1'b0)
    end
    cell_in = '{alt_set: 1'b0, reverse: 1'b0, code: 8'h41};
    for (int m = 0; m < 2; m++) begin
      dots(m[0], 8'h2a, 1'b0);
      dots(m[0], 8'hc1, 1'b1);
    end
    line(1'b0, 8'hb5, 1'b1, 1'b0, 1'b1, 1'b0);
    line(1'b0, 8'h45, 1'b0, 1'b0, 1'b0, 1'b0);
    vertical_reset = 1'b1;
    tick(6);
    `CHK(mem_addr, 15'h2000)
    vertical_reset = 1'b0;
    tick(4);
    line(1'b1, 8'he2, 1'b0, 1'b1, 1'b1, 1'b1);
    line(1'b1, 8'h7a, 1'b1, 1'b0, 1'b1, 1'b0);
    line(1'b0, 8'h13, 1'b1, 1'b0, 1'b1, 1'b0);
    conclude();
  end
endmodule

`default_nettype wire
